// [hdl/adcpp_defs.svh]
/*
  constants for the parallel conversion port: strap codes, timing counts, widths.
  assumes inclusion by bare name from design files only.
*/
// Function
// - chip select frames every transfer
// - results driven only with select and read low
// - sixteen data lines are three-state both ways
// - software mode: shared pin is write strobe
// - hardware mode: shared pin latches burst enable
// - hardware mode: pair select picks next pair
// - busy rises after conversion start edge
// - busy stays high until all channels done
// - start edges ignored while busy high
// - both range straps low gives software mode
// - rising start edge begins pair conversion
// - burst converts all pairs on one edge
`ifndef ADCPP_DEFS_SVH
`define ADCPP_DEFS_SVH
`define ADCPP_DATA_W 16
`define ADCPP_SEL_W 3
`define ADCPP_RANGE_SW 2'h0
`define ADCPP_CONV_NS 800
`define ADCPP_CLK_NS 8
`define ADCPP_CONV_CYC ((`ADCPP_CONV_NS + `ADCPP_CLK_NS - 1) / `ADCPP_CLK_NS)
`define ADCPP_NUM_PAIRS 8
`endif

// [hdl/adcpp_pkg.sv]
/*
  types for the parallel conversion port.
  assumes the defs header is available.
*/
package adcpp_pkg;
  typedef enum logic [2:0] {
    ADCPP_IDLE = 3'b001,
    ADCPP_CONV = 3'b010,
    ADCPP_DONE = 3'b100
  } adcpp_state_t;
endpackage : adcpp_pkg

// [hdl/adcpp_sync.sv]
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes clk_sys domain, synchronous active-low reset.
*/
`timescale 1ns/1ns
module adcpp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : adcpp_sync

// [hdl/adcpp_port.sv]
/*
  host-facing parallel port of a dual sampling converter: start/busy handshake,
  result readout, register write capture, strap latching, pair selection.
  assumes host pins are asynchronous; converter results arrive on conv_data_a/b.
*/
`timescale 1ns/1ns
`include "adcpp_defs.svh"
module adcpp_port #(
  parameter int DATA_W = `ADCPP_DATA_W,
  parameter int SEL_W = `ADCPP_SEL_W,
  parameter int CONV_CYC = `ADCPP_CONV_CYC,
  parameter int NUM_PAIRS = `ADCPP_NUM_PAIRS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // host strobes
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_burst_n,
  input wire logic conversion_start_in,
  input wire logic [SEL_W-1:0] pair_select,
  // straps
  input wire logic interface_strap,
  input wire logic [1:0] mode_range_straps,
  // data bus
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic [DATA_W-1:0] host_data_oe_n,
  // status
  output logic busy,
  output logic sw_mode,
  output logic burst_en,
  output logic interface_invalid,
  // converter side
  input wire logic [DATA_W-1:0] conv_data_a,
  input wire logic [DATA_W-1:0] conv_data_b,
  output logic [SEL_W-1:0] conv_pair,
  output logic conv_sample,
  // register write
  output logic [DATA_W-1:0] cmd_word,
  output logic cmd_valid
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int PW = $clog2(NUM_PAIRS + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [6+SEL_W-1:0] pins_s;
  logic cs_n_s, rd_n_s, wr_n_s, start_s, par_s;
  logic cs_a_s, rd_a_s, wr_a_s;
  logic [1:0] rng_s;
  logic [SEL_W-1:0] sel_s;
  logic [DATA_W-1:0] data_s;

  adcpp_sync #(.WIDTH(6 + SEL_W)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d({~chip_select_n, ~read_n, ~write_burst_n, conversion_start_in, interface_strap,
        mode_range_straps[0], pair_select}),
    .q(pins_s)
  );
  // select, read and write strobes pass inverted: cleared flops read idle, so no false edge after reset
  assign {cs_a_s, rd_a_s, wr_a_s, start_s, par_s, rng_s[0], sel_s} = pins_s;
  assign cs_n_s = !cs_a_s;
  assign rd_n_s = !rd_a_s;
  assign wr_n_s = !wr_a_s;

  // data word delayed like the strobes, so capture stays aligned with them
  adcpp_sync #(.WIDTH(DATA_W)) u_sync_data (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d(host_data_in),
    .q(data_s)
  );

  logic [1:0] rng_hi_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) rng_hi_reg <= 2'h0;
    else rng_hi_reg <= {rng_hi_reg[0], mode_range_straps[1]};
  end
  assign rng_s[1] = rng_hi_reg[1];

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  // straps sampled once, first cycles after release, once synchronisers are filled
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic sw_mode_reg, burst_reg, par_bad_reg;
  wire strap_take = !strap_done_reg && (strap_cnt_reg == 2'h2);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      sw_mode_reg <= 1'b1;
      burst_reg <= 1'b0;
      par_bad_reg <= 1'b0;
    end else begin
      if (!strap_done_reg) strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_take) begin
        strap_done_reg <= 1'b1;
        sw_mode_reg <= (rng_s == `ADCPP_RANGE_SW);
        burst_reg <= (rng_s != `ADCPP_RANGE_SW) && wr_n_s;
        par_bad_reg <= par_s;
      end
    end
  end

  // ----------------------------------------
  // conversion sequencing
  // ----------------------------------------
  adcpp_pkg::adcpp_state_t state_reg, state_next;
  logic start_d_reg;
  logic [CW-1:0] cyc_reg;
  logic [PW-1:0] left_reg;
  logic [SEL_W-1:0] pair_reg;
  logic [DATA_W-1:0] res_a_reg, res_b_reg, out_reg;
  logic busy_reg, sample_reg;

  wire start_rise = start_s && !start_d_reg && strap_done_reg;
  wire is_idle = (state_reg == adcpp_pkg::ADCPP_IDLE);
  wire cyc_end = (cyc_reg == CONV_LAST);
  wire last_pair = (left_reg == PW'(1));
  wire [PW-1:0] pairs_req = (!sw_mode_reg && burst_reg) ? PW'(NUM_PAIRS) : PW'(1);
  wire [SEL_W-1:0] first_pair = sw_mode_reg ? {SEL_W{1'b0}} : sel_s;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcpp_pkg::ADCPP_IDLE: begin
        if (start_rise) state_next = adcpp_pkg::ADCPP_CONV;
      end
      adcpp_pkg::ADCPP_CONV: begin
        if (cyc_end && last_pair) state_next = adcpp_pkg::ADCPP_DONE;
      end
      adcpp_pkg::ADCPP_DONE: state_next = adcpp_pkg::ADCPP_IDLE;
      default: state_next = adcpp_pkg::ADCPP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= adcpp_pkg::ADCPP_IDLE;
      start_d_reg <= 1'b0;
      cyc_reg <= '0;
      left_reg <= '0;
      pair_reg <= '0;
      busy_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_d_reg <= start_s;
      sample_reg <= 1'b0;
      if (is_idle && start_rise) begin
        busy_reg <= 1'b1;
        cyc_reg <= '0;
        left_reg <= pairs_req;
        pair_reg <= first_pair;
        sample_reg <= 1'b1;
      end else if (state_reg == adcpp_pkg::ADCPP_CONV) begin
        cyc_reg <= cyc_end ? '0 : cyc_reg + CW'(1);
        if (cyc_end && !last_pair) begin
          left_reg <= left_reg - PW'(1);
          pair_reg <= pair_reg + SEL_W'(1);
          sample_reg <= 1'b1;
        end
        if (cyc_end && last_pair) busy_reg <= 1'b0;
      end
    end
  end

  // results held in output registers on busy fall only
  wire busy_fall = (state_reg == adcpp_pkg::ADCPP_CONV) && cyc_end && last_pair;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      res_a_reg <= '0;
      res_b_reg <= '0;
    end else if (busy_fall) begin
      res_a_reg <= conv_data_a;
      res_b_reg <= conv_data_b;
    end
  end

  // ----------------------------------------
  // host bus
  // ----------------------------------------
  logic rd_d_reg, wr_d_reg, word_sel_reg, oe_n_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic cmd_v_reg;
  wire rd_act = !cs_n_s && !rd_n_s;
  wire rd_end = !rd_act && rd_d_reg;
  wire wr_act = !cs_n_s && !wr_n_s && sw_mode_reg && strap_done_reg;
  wire wr_rise = !wr_act && wr_d_reg;
  wire [DATA_W-1:0] rd_word = word_sel_reg ? res_b_reg : res_a_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
      word_sel_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      out_reg <= '0;
      cmd_reg <= '0;
      cmd_v_reg <= 1'b0;
    end else begin
      rd_d_reg <= rd_act;
      wr_d_reg <= wr_act;
      oe_n_reg <= !rd_act;
      out_reg <= rd_word;
      cmd_v_reg <= 1'b0;
      // a then b per conversion; new result restarts at a
      if (busy_fall) word_sel_reg <= 1'b0;
      else if (rd_end) word_sel_reg <= !word_sel_reg;
      if (wr_act) cmd_reg <= data_s;
      if (wr_rise) cmd_v_reg <= 1'b1;
    end
  end

  assign host_data_out = out_reg;
  assign host_data_oe_n = {DATA_W{oe_n_reg}};
  assign busy = busy_reg;
  assign sw_mode = sw_mode_reg;
  assign burst_en = burst_reg;
  assign interface_invalid = par_bad_reg;
  assign conv_pair = pair_reg;
  assign conv_sample = sample_reg;
  assign cmd_word = cmd_reg;
  assign cmd_valid = cmd_v_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_conv_run;
    busy_reg [*2];
  endsequence

  property p_busy_rise;
    @(posedge clk_sys) disable iff (!reset_n) (is_idle && start_rise) |=> busy_reg;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_busy_hold;
    @(posedge clk_sys) disable iff (!reset_n) $rose(busy_reg) |-> s_conv_run;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

  property p_ignore;
    @(posedge clk_sys) disable iff (!reset_n) (busy_reg && start_rise && !busy_fall) |=> busy_reg;
  endproperty
  a_ignore: assert property (p_ignore) else $error("start during busy acted");

  property p_latch;
    @(posedge clk_sys) disable iff (!reset_n) busy_fall |=> (res_a_reg == $past(conv_data_a));
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched");

  property p_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      !host_data_oe_n[0] |-> $past(!chip_select_n && !read_n, 3);
  endproperty
  a_drive: assert property (p_drive) else $error("bus driven without read");

  property p_hiz;
    @(posedge clk_sys) disable iff (!reset_n) (cs_n_s || rd_n_s) |=> host_data_oe_n[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus not released");

  property p_cs;
    @(posedge clk_sys) disable iff (!reset_n) cmd_v_reg |-> $past(!chip_select_n, 4);
  endproperty
  a_cs: assert property (p_cs) else $error("strobe taken without select");

  property p_wr_sw;
    @(posedge clk_sys) disable iff (!reset_n) cmd_v_reg |-> sw_mode_reg;
  endproperty
  a_wr_sw: assert property (p_wr_sw) else $error("write in hardware mode");

  property p_mode;
    @(posedge clk_sys) disable iff (!reset_n) strap_done_reg |=> $stable(sw_mode_reg);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed without reset");
endmodule : adcpp_port

// [verif/adcpp_host_model.sv]
/*
  host model: pin-level tasks for reads, writes and conversion starts.
  assumes clk_sys of the port; pins change 1 ns after a rising edge.
*/
`timescale 1ns/1ns
module adcpp_host_model (
  // clock
  input wire logic clk_sys,
  // strobes and bus drive
  output logic chip_select_n,
  output logic read_n,
  output logic write_burst_n,
  output logic conversion_start_in,
  output logic [15:0] host_drive,
  output logic host_drive_en,
  // device answers
  input wire logic [15:0] host_data_out,
  input wire logic [15:0] host_data_oe_n,
  input wire logic busy
);
  int timeouts = 0;
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_burst_n = 1'b1;
    conversion_start_in = 1'b0;
    host_drive = 16'h0000;
    host_drive_en = 1'b0;
  end
  // -------------------------
  // pin tasks
  // -------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) tick(1);
    if (busy !== v) timeouts++;
  endtask : wait_busy
  // hold select and read until the bus is driven
  task automatic rd(input logic cs_n, output logic [15:0] w, output logic [15:0] oe);
    tick(1);
    chip_select_n = cs_n;
    read_n = 1'b0;
    for (int i = 0; i < 8 && host_data_oe_n !== 16'h0000; i++) tick(1);
    if (host_data_oe_n !== 16'h0000 && !cs_n) timeouts++;
    w = host_data_out;
    oe = host_data_oe_n;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    tick(6);
  endtask : rd
  // data held one cycle past the strobe, covering sampling skew of the pins
  task automatic wr(input logic [15:0] w, input logic cs_n);
    tick(1);
    host_drive = w;
    host_drive_en = 1'b1;
    chip_select_n = cs_n;
    write_burst_n = 1'b0;
    tick(4);
    write_burst_n = 1'b1;
    chip_select_n = 1'b1;
    tick(1);
    host_drive_en = 1'b0;
  endtask : wr
  task automatic pulse;
    tick(1);
    conversion_start_in = 1'b1;
    tick(3);
    conversion_start_in = 1'b0;
  endtask : pulse
  task automatic start(input int bound);
    pulse();
    wait_busy(1'b1, 8);
    pulse();
    wait_busy(1'b0, bound);
  endtask : start
endmodule : adcpp_host_model

// [verif/tb.sv]
/*
  testbench for adcpp_port: straps, writes, conversions, reads.
  assumes the host model and the port; converter results follow the pair.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
  localparam int CC = 12;
  logic clk_sys, reset_n, interface_strap, busy, sw_mode, burst_en, interface_invalid;
  logic cmd_valid, conv_sample, seen;
  logic [2:0] pair_select, conv_pair;
  logic [1:0] mode_range_straps;
  logic [15:0] host_data_in, host_data_out, host_data_oe_n, conv_data_a, conv_data_b;
  logic [15:0] cmd_word, host_drive, w, oe;
  logic [15:0] float_pat = 16'h5A5A;
  logic cs_n, rd_n, wb_n, cs_in, drv_en;
  int checks = 0;
  int n_mismatch = 0;
  int bcnt = 0;
  int scnt = 0;
  // -------------------------
  // clock, converter, bus
  // -------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) float_pat <= ~float_pat;
  always @(posedge clk_sys) if (busy === 1'b1) bcnt++;
  always @(posedge clk_sys) if (conv_sample === 1'b1) scnt++;
  assign conv_data_a = {13'h1400, conv_pair};
  assign conv_data_b = {13'h1600, conv_pair};
  // released bus shows a toggling pattern, not the last word
  assign host_data_in = (~host_data_oe_n & host_data_out)
    | (host_data_oe_n & (drv_en ? host_drive : float_pat));
  adcpp_port #(.CONV_CYC(CC)) adcpp_port_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .chip_select_n(cs_n), .read_n(rd_n), .write_burst_n(wb_n),
    .conversion_start_in(cs_in), .pair_select(pair_select),
    .interface_strap(interface_strap), .mode_range_straps(mode_range_straps),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .busy(busy), .sw_mode(sw_mode),
    .burst_en(burst_en), .interface_invalid(interface_invalid),
    .conv_data_a(conv_data_a), .conv_data_b(conv_data_b), .conv_pair(conv_pair),
    .conv_sample(conv_sample), .cmd_word(cmd_word), .cmd_valid(cmd_valid));
  adcpp_host_model adcpp_host_model_inst (.clk_sys(clk_sys), .chip_select_n(cs_n),
    .read_n(rd_n), .write_burst_n(wb_n), .conversion_start_in(cs_in),
    .host_drive(host_drive), .host_drive_en(drv_en), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .busy(busy));
  // -------------------------
  // tasks
  // -------------------------
  task automatic summarize;
    n_mismatch += adcpp_host_model_inst.timeouts;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic do_reset(input logic [1:0] rng, input logic bst, input logic [2:0] ps);
    mode_range_straps = rng;
    adcpp_host_model_inst.write_burst_n = bst;
    pair_select = ps;
    reset_n = 1'b0;
    adcpp_host_model_inst.tick(20);
    reset_n = 1'b1;
    adcpp_host_model_inst.tick(8);
  endtask : do_reset
  task automatic wr_chk(input logic [15:0] v, input logic c_n);
    seen = 1'b0;
    adcpp_host_model_inst.wr(v, c_n);
    for (int i = 0; i < 8; i++) begin
      if (cmd_valid === 1'b1) seen = 1'b1;
      adcpp_host_model_inst.tick(1);
    end
    `CHK(seen, ~c_n)
  endtask : wr_chk
  // second start edge lands while busy and must not extend it
  task automatic conv(input int pairs);
    bcnt = 0;
    scnt = 0;
    adcpp_host_model_inst.start(pairs * CC + 40);
    adcpp_host_model_inst.tick(20);
    `CHK(scnt, pairs)
    `CHK(bcnt >= pairs * CC, 1'b1)
    `CHK(bcnt <= pairs * CC + 3, 1'b1)
  endtask : conv
  // -------------------------
  // sequence
  // -------------------------
  initial begin
    reset_n = 1'b0;
    interface_strap = 1'b0;
    do_reset(2'h0, 1'b1, 3'h0);
    `CHK(sw_mode, 1'b1)
    `CHK(burst_en, 1'b0)
    `CHK(host_data_oe_n, 16'hFFFF)
    wr_chk(16'h1234, 1'b0);
    `CHK(cmd_word, 16'h1234)
    wr_chk(16'h4321, 1'b1);
    `CHK(cmd_word, 16'h1234)
    conv(1);
    adcpp_host_model_inst.rd(1'b1, w, oe);
    `CHK(oe, 16'hFFFF)
    adcpp_host_model_inst.rd(1'b0, w, oe);
    `CHK(oe, 16'h0000)
    `CHK(w, 16'hA000)
    adcpp_host_model_inst.rd(1'b0, w, oe);
    `CHK(w, 16'hB000)
    `CHK(host_data_oe_n, 16'hFFFF)
    do_reset(2'h3, 1'b0, 3'h1);
    `CHK(sw_mode, 1'b0)
    `CHK(burst_en, 1'b0)
    conv(1);
    adcpp_host_model_inst.rd(1'b0, w, oe);
    `CHK(w, 16'hA001)
    do_reset(2'h1, 1'b1, 3'h2);
    adcpp_host_model_inst.write_burst_n = 1'b0;
    adcpp_host_model_inst.tick(4);
    `CHK(burst_en, 1'b1)
    adcpp_host_model_inst.write_burst_n = 1'b1;
    conv(8);
    adcpp_host_model_inst.rd(1'b0, w, oe);
    `CHK(w, 16'hA001)
    interface_strap = 1'b1;
    do_reset(2'h2, 1'b0, 3'h0);
    `CHK(interface_invalid, 1'b1)
    summarize();
  end
endmodule : tb
